// ---- logic/gpio_pkg.sv ----
// constants and carrier types of the gpio port function select block
package gpio_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_FN0 = 32'hFFFF0D00;
  localparam logic [31:0] ADDR_FN1 = 32'hFFFF0D04;
  localparam logic [31:0] ADDR_FN2 = 32'hFFFF0D08;
  localparam logic [31:0] ADDR_DAT0 = 32'hFFFF0D20;
  localparam logic [31:0] ADDR_SET0 = 32'hFFFF0D24;
  localparam logic [31:0] ADDR_CLR0 = 32'hFFFF0D28;
  localparam logic [31:0] ADDR_DAT1 = 32'hFFFF0D30;
  localparam logic [31:0] ADDR_SET1 = 32'hFFFF0D34;
  localparam logic [31:0] ADDR_CLR1 = 32'hFFFF0D38;
  localparam logic [31:0] ADDR_DAT2 = 32'hFFFF0D40;
  localparam logic [31:0] ADDR_SET2 = 32'hFFFF0D44;
  localparam logic [31:0] ADDR_CLR2 = 32'hFFFF0D48;
  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [31:0] FN0_RESET = 32'h11100000;
  localparam logic [31:0] FN1_RESET = 32'h10000000;
  localparam logic [31:0] FN2_RESET = 32'h01000000;
  localparam logic [31:0] FN0_MASK = 32'h11111111;
  localparam logic [31:0] FN1_MASK = 32'h10000011;
  localparam logic [31:0] FN2_MASK = 32'h01110011;
  localparam logic [7:0] P0_MASK = 8'h7F;
  localparam logic [7:0] P1_MASK = 8'h03;
  localparam logic [7:0] P2_MASK = 8'h73;
  localparam logic [7:0] DAT_RESET = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FN0_SS = 0;
  localparam int FN0_SCLK = 4;
  localparam int FN0_MISO = 8;
  localparam int FN0_MOSI = 12;
  localparam int FN0_CLKOUT = 16;
  localparam int FN0_HV_A = 20;
  localparam int FN0_HV_B = 24;
  localparam int FN1_RXD = 0;
  localparam int FN1_TXD = 4;
  localparam int FN2_LIN_READ = 0;
  localparam int FN2_LIN_DRIVE = 4;
  localparam int FN2_LIN_RX_ROUTE = 16;
  localparam int FN2_LIN_TX_ROUTE = 20;
  localparam int FN2_STI = 24;
  localparam int DAT_IN_LSB = 0;
  localparam int DAT_OUT_LSB = 8;
  localparam int DAT_DIR_LSB = 16;
  // ----------------------------------------
  // timing and bus answers
  // ----------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int CLKOUT_KHZ = 2560;
  localparam logic [16:0] CLKOUT_STEP = 17'(2 * CLKOUT_KHZ);
  localparam logic [16:0] CLKOUT_MOD = 17'(CLK_KHZ);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] value;
    logic [8:0] enable;
  } pin_drive_s;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RESP = 2'b10} bus_state_e;
endpackage

// ---- logic/gpio_port_function_select.sv ----
// nine-pin gpio block with alternate function select and axi4-lite registers
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module gpio_port_function_select
  import gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [8:0] pin_in,
  output logic [8:0] pin_out,
  output logic [8:0] pin_oe,
  input wire gpio_pkg::pin_drive_s alt_drive,
  input wire logic power_down,
  output logic [3:0] ext_irq,
  output logic hv_line_a_out,
  output logic hv_line_a_oe,
  input wire logic hv_line_a_in,
  output logic hv_line_b_out,
  output logic hv_line_b_oe,
  input wire logic hv_line_b_in,
  input wire logic diag_readback_in,
  output logic lin_rx_route_en,
  input wire logic uart_tx_in,
  output logic lin_tx_data,
  input wire logic lin_pin_level,
  output logic lin_test_drive,
  output logic lin_test_drive_en,
  input wire logic sti_data_in,
  output logic serial_test_output
);
  import gpio_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return (a == ADDR_FN0) || (a == ADDR_FN1) || (a == ADDR_FN2) ||
           (a == ADDR_DAT0) || (a == ADDR_SET0) || (a == ADDR_CLR0) ||
           (a == ADDR_DAT1) || (a == ADDR_SET1) || (a == ADDR_CLR1) ||
           (a == ADDR_DAT2) || (a == ADDR_SET2) || (a == ADDR_CLR2);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  bus_state_e wr_state_reg, wr_state_next, rd_state_reg, rd_state_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] fn0_reg, fn0_next, fn1_reg, fn1_next, fn2_reg, fn2_next;
  logic [7:0] dir_reg [3];
  logic [7:0] dir_next [3];
  logic [7:0] out_reg [3];
  logic [7:0] out_next [3];
  logic [16:0] clk_acc_reg, clk_acc_next;
  logic clkout_reg, clkout_next;
  pin_drive_s drive_reg, drive_next;
  logic [3:0] irq_reg, irq_next;
  logic [7:0] in_view [3];
  logic [31:0] w_addr, w_data;
  logic [3:0] w_strb;
  logic do_write;

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  assign awready = ce && (wr_state_reg == BUS_IDLE) && !aw_have_reg;
  assign wready = ce && (wr_state_reg == BUS_IDLE) && !w_have_reg;
  assign arready = ce && (rd_state_reg == BUS_IDLE);
  assign bvalid = (wr_state_reg == BUS_RESP);
  assign rvalid = (rd_state_reg == BUS_RESP);
  assign bresp = bresp_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign w_addr = aw_have_reg ? awaddr_reg : awaddr;
  assign w_data = w_have_reg ? wdata_reg : wdata;
  assign w_strb = w_have_reg ? wstrb_reg : wstrb;
  assign do_write = ce && (wr_state_reg == BUS_IDLE) && (aw_have_reg || awvalid) &&
                    (w_have_reg || wvalid);

  // ----------------------------------------
  // pin readback
  // ----------------------------------------
  // hv lines and pins 11..13 live inside the chip; only their values show here
  assign in_view[0] = {1'b0, hv_line_b_in, hv_line_a_in, pin_in[4:0]};
  assign in_view[1] = {6'h00, pin_in[6:5]};
  assign in_view[2] = {1'b0, out_reg[2][6:5], diag_readback_in, 2'b00, pin_in[8:7]};

  // ----------------------------------------
  // bus and registers next state
  // ----------------------------------------
  always_comb
  begin
    wr_state_next = wr_state_reg;
    rd_state_next = rd_state_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    fn0_next = fn0_reg;
    fn1_next = fn1_reg;
    fn2_next = fn2_reg;
    dir_next = dir_reg;
    out_next = out_reg;
    if (ce)
    begin
      case (wr_state_reg)
        BUS_IDLE:
        begin
          if (do_write)
          begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            wr_state_next = BUS_RESP;
            bresp_next = mapped(w_addr) ? RESP_OKAY : RESP_SLVERR;
            case (w_addr)
              ADDR_FN0: fn0_next = merge(fn0_reg, w_data, w_strb) & FN0_MASK;
              ADDR_FN1: fn1_next = merge(fn1_reg, w_data, w_strb) & FN1_MASK;
              ADDR_FN2: fn2_next = merge(fn2_reg, w_data, w_strb) & FN2_MASK;
              default:
              begin
                for (int p = 0; p < 3; p++)
                begin
                  logic [7:0] pm;
                  logic [31:0] dat;
                  pm = (p == 0) ? P0_MASK : ((p == 1) ? P1_MASK : P2_MASK);
                  dat = merge({8'h00, dir_reg[p], out_reg[p], 8'h00}, w_data, w_strb);
                  if (w_addr == ADDR_DAT0 + 32'(p * 16))
                  begin
                    dir_next[p] = dat[DAT_DIR_LSB +: 8] & pm;
                    out_next[p] = dat[DAT_OUT_LSB +: 8] & pm;
                  end
                  if ((w_addr == ADDR_SET0 + 32'(p * 16)) && w_strb[0])
                    out_next[p] = out_reg[p] | (w_data[7:0] & pm);
                  if ((w_addr == ADDR_CLR0 + 32'(p * 16)) && w_strb[0])
                    out_next[p] = out_reg[p] & ~(w_data[7:0] & pm);
                end
              end
            endcase
          end
          else
          begin
            if (awvalid && !aw_have_reg)
            begin
              aw_have_next = 1'b1;
              awaddr_next = awaddr;
            end
            if (wvalid && !w_have_reg)
            begin
              w_have_next = 1'b1;
              wdata_next = wdata;
              wstrb_next = wstrb;
            end
          end
        end
        BUS_RESP:
        begin
          if (bready)
            wr_state_next = BUS_IDLE;
        end
        default: wr_state_next = BUS_IDLE;
      endcase
      case (rd_state_reg)
        BUS_IDLE:
        begin
          if (arvalid)
          begin
            rd_state_next = BUS_RESP;
            rresp_next = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_next = 32'h00000000;
            case (araddr)
              ADDR_FN0: rdata_next = fn0_reg;
              ADDR_FN1: rdata_next = fn1_reg;
              ADDR_FN2: rdata_next = fn2_reg;
              ADDR_DAT0: rdata_next = {8'h00, dir_reg[0], out_reg[0], in_view[0]};
              ADDR_DAT1: rdata_next = {8'h00, dir_reg[1], out_reg[1], in_view[1]};
              ADDR_DAT2: rdata_next = {8'h00, dir_reg[2], out_reg[2], in_view[2]};
              default: rdata_next = 32'h00000000;
            endcase
          end
        end
        BUS_RESP:
        begin
          if (rready)
            rd_state_next = BUS_IDLE;
        end
        default: rd_state_next = BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin functions next state
  // ----------------------------------------
  always_comb
  begin
    pin_drive_s d;
    d.value = 9'h000;
    d.enable = 9'h000;
    clk_acc_next = clk_acc_reg;
    clkout_next = clkout_reg;
    // fractional step: 125 MHz is no whole multiple of the clock out, so edges jitter one cycle
    if (clk_acc_reg + CLKOUT_STEP >= CLKOUT_MOD)
    begin
      clk_acc_next = clk_acc_reg + CLKOUT_STEP - CLKOUT_MOD;
      clkout_next = !clkout_reg;
    end
    else
      clk_acc_next = clk_acc_reg + CLKOUT_STEP;
    // gpio view first, alternates override below
    for (int i = 0; i < 5; i++)
    begin
      d.value[i] = out_reg[0][i];
      d.enable[i] = dir_reg[0][i];
    end
    for (int i = 0; i < 2; i++)
    begin
      d.value[5 + i] = out_reg[1][i];
      d.enable[5 + i] = dir_reg[1][i];
      d.value[7 + i] = out_reg[2][i];
      d.enable[7 + i] = dir_reg[2][i];
    end
    if (fn0_reg[FN0_SS])
    begin
      d.value[0] = alt_drive.value[0];
      d.enable[0] = alt_drive.enable[0];
    end
    if (fn0_reg[FN0_SCLK])
    begin
      d.value[1] = alt_drive.value[1];
      d.enable[1] = alt_drive.enable[1];
    end
    if (fn0_reg[FN0_MISO])
    begin
      d.value[2] = alt_drive.value[2];
      d.enable[2] = alt_drive.enable[2];
    end
    if (fn0_reg[FN0_MOSI])
    begin
      d.value[3] = alt_drive.value[3];
      d.enable[3] = alt_drive.enable[3];
    end
    if (fn0_reg[FN0_CLKOUT])
    begin
      d.value[4] = clkout_reg;
      d.enable[4] = 1'b1;
    end
    if (fn1_reg[FN1_RXD])
    begin
      d.value[5] = alt_drive.value[5];
      d.enable[5] = alt_drive.enable[5];
    end
    if (fn1_reg[FN1_TXD])
    begin
      d.value[6] = alt_drive.value[6];
      d.enable[6] = alt_drive.enable[6];
    end
    if (fn2_reg[FN2_LIN_READ])
    begin
      d.value[7] = lin_pin_level;
      d.enable[7] = 1'b1;
    end
    if (fn2_reg[FN2_LIN_DRIVE])
      d.enable[8] = 1'b0;
    // power-down freezes the pins at their last driven level
    drive_next = power_down ? drive_reg : d;
    // pin samples pass through unlatched; one flop of delay only
    irq_next = {pin_in[8], pin_in[7], pin_in[5], pin_in[0]};
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_reg <= BUS_IDLE;
      rd_state_reg <= BUS_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
      fn0_reg <= FN0_RESET;
      fn1_reg <= FN1_RESET;
      fn2_reg <= FN2_RESET;
      for (int p = 0; p < 3; p++)
      begin
        dir_reg[p] <= DAT_RESET;
        out_reg[p] <= DAT_RESET;
      end
      clk_acc_reg <= 17'h00000;
      clkout_reg <= 1'b0;
      drive_reg <= '0;
      irq_reg <= 4'h0;
    end
    else if (ce)
    begin
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      fn0_reg <= fn0_next;
      fn1_reg <= fn1_next;
      fn2_reg <= fn2_next;
      dir_reg <= dir_next;
      out_reg <= out_next;
      clk_acc_reg <= clk_acc_next;
      clkout_reg <= clkout_next;
      drive_reg <= drive_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pin_out = drive_reg.value;
  assign pin_oe = drive_reg.enable;
  assign ext_irq = irq_reg;
  assign hv_line_a_out = out_reg[0][5];
  assign hv_line_a_oe = fn0_reg[FN0_HV_A] && dir_reg[0][5];
  assign hv_line_b_out = out_reg[0][6];
  assign hv_line_b_oe = fn0_reg[FN0_HV_B] && dir_reg[0][6];
  assign lin_rx_route_en = fn2_reg[FN2_LIN_RX_ROUTE];
  assign lin_tx_data = fn2_reg[FN2_LIN_TX_ROUTE] ? uart_tx_in : out_reg[2][5];
  assign lin_test_drive = pin_in[8];
  assign lin_test_drive_en = fn2_reg[FN2_LIN_DRIVE];
  assign serial_test_output = fn2_reg[FN2_STI] ? sti_data_in : out_reg[2][6];
endmodule

// ---- verification/gpio_board_model.sv ----
// board side of the gpio pins: pads with pull-ups and outside drivers
`timescale 1ns/100ps
module gpio_board_model
(
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe,
  input wire logic [8:0] ext_en,
  input wire logic [8:0] ext_val,
  output logic [8:0] pin_in
);
  // --------
  // pad resolution
  // --------
  // an undriven pad rests high through its pull-up, never at the last value
  always_comb
  begin
    for (int i = 0; i < 9; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

// ---- verification/gpio_port_function_select_asserts.sv ----
// port-level assertions of the gpio port function select block
`timescale 1ns/100ps
module gpio_port_function_select_asserts
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [8:0] pin_in,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe,
  input wire logic power_down,
  input wire logic [3:0] ext_irq,
  input wire logic lin_test_drive,
  input wire logic lin_test_drive_en
);
  default clocking ck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // --------
  // bus steps
  // --------
  sequence wr_taken;
    ce && awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    ce && arvalid && arready;
  endsequence
  sequence rd_waiting;
    rvalid && !rready;
  endsequence
  // --------
  // checks
  // --------
  reset_state_a: assert property ($rose(aresetn) && $past(ce) |->
    !bvalid && !rvalid && pin_oe == 9'h000 && ext_irq == 4'h0)
    else $error("state not cleared by reset");
  irq_follow_a: assert property (ce |=> ext_irq ==
    {$past(pin_in[8]), $past(pin_in[7]), $past(pin_in[5]), $past(pin_in[0])})
    else $error("interrupt lines do not follow the pins");
  power_hold_a: assert property (ce && power_down |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved in power down");
  lin_drive_a: assert property (lin_test_drive == pin_in[8] &&
    !($past(lin_test_drive_en) && $past(ce) && !$past(power_down) && pin_oe[8]))
    else $error("lin drive pin not released or not followed");
  write_answer_a: assert property (wr_taken |=> bvalid)
    else $error("write not answered");
  read_answer_a: assert property (rd_taken |=> rvalid)
    else $error("read not answered");
  read_hold_a: assert property (rd_waiting |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped or changed");
  read_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
endmodule
bind gpio_port_function_select gpio_port_function_select_asserts i_asserts (.aclk, .aresetn,
  .ce, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .power_down, .ext_irq, .lin_test_drive,
  .lin_test_drive_en);

// ---- verification/test_gpio_port_function_select.sv ----
// self-checking bench of the gpio port function select block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_gpio_port_function_select;
  import gpio_pkg::*;
  localparam int LO[3] = '{0, 5, 7};
  localparam int NB[3] = '{5, 2, 2};
  localparam logic [31:0] DA[3] = '{ADDR_DAT0, ADDR_DAT1, ADDR_DAT2};
  localparam logic [7:0] PM[3] = '{P0_MASK, P1_MASK, P2_MASK};
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, power_down = 0, lin_pin_level = 0, hv_line_a_in = 0, hv_line_b_in = 0;
  logic diag_readback_in = 0, uart_tx_in = 0, sti_data_in = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rm;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] ext_irq, prev;
  logic awready, wready, bvalid, arready, rvalid, hv_line_a_out, hv_line_a_oe, hv_line_b_out;
  logic hv_line_b_oe, lin_test_drive, lin_test_drive_en, serial_test_output, last;
  logic lin_rx_route_en, lin_tx_data;
  logic [1:0] bresp, rresp, we;
  logic [8:0] pin_in, pin_out, pin_oe, ext_en = 0, ext_val = 0;
  logic [7:0] dir, out, s;
  logic [33:0] re;
  logic [33:0] rq[$];
  logic [31:0] rmask[$];
  logic [1:0] wq[$];
  pin_drive_s alt_drive = '0;
  pin_drive_s av;
  integer seed = 54, miscompares = 0, checks_done = 0, tg;
  gpio_port_function_select i_gpio_port_function_select (.aclk, .aresetn, .ce, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe,
    .alt_drive, .power_down, .ext_irq, .hv_line_a_out, .hv_line_a_oe, .hv_line_a_in,
    .hv_line_b_out, .hv_line_b_oe, .hv_line_b_in, .diag_readback_in, .lin_rx_route_en,
    .uart_tx_in, .lin_tx_data, .lin_pin_level, .lin_test_drive, .lin_test_drive_en,
    .sti_data_in, .serial_test_output);
  gpio_board_model i_gpio_board_model (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
  initial
  begin
    forever #4 aclk = ~aclk;
  end
  // --------
  // peripherals and bus tasks
  // --------
  // peripheral lines change every cycle so a stale value never passes
  always @(posedge aclk)
  begin
    {alt_drive, hv_line_a_in, hv_line_b_in, diag_readback_in, uart_tx_in, sti_data_in} <=
      23'($random(seed));
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    logic aw, w, b;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 0;
    for (int n = 0; n < 60 && !b; n++)
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    if (!b) miscompares++;
    if (!b) report_and_stop();
  endtask
  // rready waits for the answer so the slave must hold it a cycle
  task automatic rd(input logic [31:0] a, e, m, input logic [1:0] r);
    logic ar, v, done;
    rq.push_back({r, e});
    rmask.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    done = 0;
    for (int n = 0; n < 60 && !done; n++)
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      done = rvalid && rready;
      v = rvalid;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      rready <= v && !done;
    end
    if (!done) miscompares++;
    if (!done) report_and_stop();
  endtask
  task automatic chk_pins(input int lo, nb, input logic [7:0] d, o);
    logic [8:0] m;
    m = 9'((1 << nb) - 1);
    @(posedge aclk);
    @(negedge aclk);
    `CHK("pin_oe", 9'(d) & m, (pin_oe >> lo) & m)
    `CHK("pin_out", 9'(d & o) & m, ((pin_out & pin_oe) >> lo) & m)
    @(posedge aclk);
  endtask
  always @(negedge aclk)
  begin
    if (bvalid && bready && wq.size() > 0)
    begin
      we = wq.pop_front();
      `CHK("bresp", we, bresp)
    end
    if (rvalid && rready && rq.size() > 0)
    begin
      re = rq.pop_front();
      rm = rmask.pop_front();
      `CHK("rresp", re[33:32], rresp)
      `CHK("rdata", re[31:0] & rm, rdata & rm)
    end
  end
  initial
  begin
    repeat (100000) @(posedge aclk);
    miscompares++;
    report_and_stop();
  end
  // --------
  // scenarios
  // --------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_FN0, FN0_RESET, '1, RESP_OKAY);
    rd(ADDR_FN1, FN1_RESET, '1, RESP_OKAY);
    rd(ADDR_FN2, FN2_RESET, '1, RESP_OKAY);
    rd(32'hFFFF0D10, 32'h0, '1, RESP_SLVERR);
    wr(32'hFFFF0D10, 32'hFFFFFFFF, RESP_SLVERR);
    rd(ADDR_SET0, 32'h0, '1, RESP_OKAY);
    chk_pins(0, 9, 8'h00, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      dir = 8'($random(seed)) & PM[k % 3];
      out = 8'($random(seed)) & PM[k % 3];
      wr(DA[k % 3], {8'h00, dir, out, 8'h00}, RESP_OKAY);
      rd(DA[k % 3], {8'h00, dir, out, 8'h00}, 32'h00FFFF00, RESP_OKAY);
      chk_pins(LO[k % 3], NB[k % 3], dir, out);
      s = 8'($random(seed)) & PM[k % 3];
      out = out | s;
      wr(DA[k % 3] + 32'h4, {24'h0, s}, RESP_OKAY);
      chk_pins(LO[k % 3], NB[k % 3], dir, out);
      s = 8'($random(seed)) & PM[k % 3];
      out = out & ~s;
      wr(DA[k % 3] + 32'h8, {24'h0, s}, RESP_OKAY);
      chk_pins(LO[k % 3], NB[k % 3], dir, out);
      wr(DA[k % 3], 32'h0, RESP_OKAY);
    end
    $display("test ports done");
    ext_en <= 9'h1FF;
    for (int k = 0; k < 30; k++)
    begin
      ext_val <= 9'($random(seed));
      @(negedge aclk);
      prev = {pin_in[8], pin_in[7], pin_in[5], pin_in[0]};
      @(posedge aclk);
      @(negedge aclk);
      `CHK("ext_irq", prev, ext_irq)
      @(posedge aclk);
    end
    $display("test interrupts done");
    wr(ADDR_FN0, FN0_RESET | 32'h00011111, RESP_OKAY);
    for (int k = 0; k < 20; k++)
    begin
      @(negedge aclk);
      av = alt_drive;
      @(posedge aclk);
      @(negedge aclk);
      `CHK("alt_oe", av.enable[3:0], pin_oe[3:0])
      `CHK("alt_out", av.value[3:0] & av.enable[3:0], pin_out[3:0] & pin_oe[3:0])
      @(posedge aclk);
    end
    // 10 us of a 2.56 MHz clock gives about 51 level changes
    @(negedge aclk);
    last = pin_out[4];
    tg = 0;
    for (int k = 0; k < 1250; k++)
    begin
      @(negedge aclk);
      if (pin_out[4] !== last) tg++;
      last = pin_out[4];
    end
    `CHK("clk_out", 2'b11, {pin_oe[4], 1'(tg >= 50 && tg <= 52)})
    @(posedge aclk);
    // clock enable low must freeze the clock out as well
    ce <= 1'b0;
    @(negedge aclk);
    last = pin_out[4];
    tg = 0;
    repeat (60) @(negedge aclk) if (pin_out[4] !== last) tg++;
    `CHK("ce_freeze", 0, tg)
    @(posedge aclk);
    ce <= 1'b1;
    $display("test alternates done");
    wr(ADDR_FN0, FN0_RESET, RESP_OKAY);
    wr(ADDR_DAT0, {8'h00, 8'h1F, 8'h15, 8'h00}, RESP_OKAY);
    chk_pins(0, 5, 8'h1F, 8'h15);
    power_down <= 1'b1;
    wr(ADDR_DAT0, {8'h00, 8'h1F, 8'h0A, 8'h00}, RESP_OKAY);
    chk_pins(0, 5, 8'h1F, 8'h15);
    power_down <= 1'b0;
    chk_pins(0, 5, 8'h1F, 8'h0A);
    wr(ADDR_DAT0, {8'h00, 8'h60, 8'h20, 8'h00}, RESP_OKAY);
    @(negedge aclk);
    `CHK("hv_lines", 4'hE, {hv_line_a_oe, hv_line_a_out, hv_line_b_oe, hv_line_b_out})
    `CHK("hv_pins", 5'h00, pin_oe[4:0])
    `CHK("sti_route", sti_data_in, serial_test_output)
    @(posedge aclk);
    $display("test power and link done");
    lin_pin_level <= 1'b1;
    // pins 7 and 8 as outputs first, so the lin alternates must override them
    wr(ADDR_DAT2, {8'h00, 8'h03, 8'h00, 8'h00}, RESP_OKAY);
    wr(ADDR_FN2, 32'h00000011, RESP_OKAY);
    @(negedge aclk);
    `CHK("lin_read", 4'hE, {pin_oe[7], pin_out[7], lin_test_drive_en, pin_oe[8]})
    `CHK("lin_drive", ext_val[8], lin_test_drive)
    @(posedge aclk);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_SET2 + 32'(4 * k), 32'h60, RESP_OKAY);
      @(negedge aclk);
      `CHK("sti_gpio", {2{1'(1 - k)}}, {serial_test_output, lin_tx_data})
      @(posedge aclk);
    end
    wr(ADDR_FN2, 32'h00110000, RESP_OKAY);
    @(negedge aclk);
    `CHK("lin_route", {1'b1, uart_tx_in}, {lin_rx_route_en, lin_tx_data})
    @(posedge aclk);
    $display("test lin and test output done");
    report_and_stop();
  end
endmodule
